// >>> src/jog_defs.svh
`ifndef JOG_DEFS_SVH
`define JOG_DEFS_SVH

// parameter addresses on the fieldbus parameter port
`define JOG_OFS_SLOW_SPEED    16'h2908
`define JOG_OFS_FAST_SPEED    16'h290A
`define JOG_OFS_STEP_DIST     16'h290E
`define JOG_OFS_WAIT_TIME     16'h2910

// factory settings
`define JOG_RST_SLOW_SPEED    16'h003C
`define JOG_RST_FAST_SPEED    16'h00B4
`define JOG_RST_STEP_DIST     32'h00000014
`define JOG_RST_WAIT_TIME     16'h01F4
`define JOG_RST_REQUEST       16'h0000

// accepted ranges
`define JOG_SPEED_MAX         16'h3390
`define JOG_STEP_MAX          32'h7FFFFFFF
`define JOG_WAIT_MIN          16'h0001
`define JOG_WAIT_MAX          16'h7FFF

// request field bit positions
`define JOG_BIT_POS           0
`define JOG_BIT_NEG           1
`define JOG_BIT_FAST          2

// wait time base: one millisecond at a 4 ns clock
`define JOG_TICK_NS           1000000
`define JOG_CLK_PERIOD_NS     4
`define JOG_CYCLES_PER_MS     (`JOG_TICK_NS / `JOG_CLK_PERIOD_NS)
`define JOG_PRESC_W           18

`endif

// >>> src/jog_pkg.sv
`include "jog_defs.svh"
package jog_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_STEP, ST_CONT, ST_STOP} jog_state_e;

    // parameter port request and answer
    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } par_req_s;

    typedef struct packed {
        logic [31:0] rdata;
        logic        valid;
        logic        err;
    } par_rsp_s;

    typedef struct packed {
        logic [15:0] slow_jog_speed;
        logic [15:0] fast_jog_speed;
        logic [31:0] jog_step_distance;
        logic [15:0] continuous_wait_time;
    } par_s;

    // command to the motion profile generator
    typedef struct packed {
        logic [31:0] target_position;
        logic [15:0] speed_ref;
        logic        dir_neg;
        logic        step_active;
        logic        continuous_run;
    } motion_cmd_s;

    typedef struct packed {
        logic [`JOG_PRESC_W-1:0] presc;
        logic [15:0]             ms_cnt;
        logic                    expired;
    } timer_st_s;

endpackage

// >>> src/jog_wait_timer.sv
`include "jog_defs.svh"
module jog_wait_timer #(
    parameter int CYCLES_PER_MS = `JOG_CYCLES_PER_MS
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    // control
    input  wire logic        start,
    input  wire logic [15:0] wait_ms,
    // status
    output logic             expired
);
    import jog_pkg::*;

    timer_st_s st_reg;
    timer_st_s st_next;

    // millisecond prescaler feeding a millisecond counter
    always_comb begin
        st_next = st_reg;
        if (start) begin
            st_next = '0;
        end else if (!st_reg.expired) begin
            if (st_reg.presc == `JOG_PRESC_W'(CYCLES_PER_MS - 1)) begin
                st_next.presc  = '0;
                st_next.ms_cnt = st_reg.ms_cnt + 16'h0001;
                // >= guards against the wait time shrinking mid-count
                if (st_reg.ms_cnt + 16'h0001 >= wait_ms) begin
                    st_next.expired = 1'b1;
                end
            end else begin
                st_next.presc = st_reg.presc + `JOG_PRESC_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign expired = st_reg.expired;

endmodule // jog_wait_timer

// >>> src/jog_motion_sequencer.sv
`include "jog_defs.svh"
module jog_motion_sequencer #(
    parameter int CYCLES_PER_MS = `JOG_CYCLES_PER_MS
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 clk_en,
    // fieldbus parameter port
    input  wire jog_pkg::par_req_s    par_req,
    output jog_pkg::par_rsp_s         par_rsp,
    // host jog control
    input  wire logic [15:0]          jog_request_bits,
    input  wire logic                 mode_active,
    input  wire logic                 halt_req,
    input  wire logic                 fault,
    // drive feedback
    input  wire logic [31:0]          actual_position,
    input  wire logic                 motor_standstill,
    input  wire logic [15:0]          ramp_speed_ceiling,
    // motion command and status
    output jog_pkg::motion_cmd_s      motion_cmd,
    output logic                      jog_busy,
    output logic                      jog_done
);
    import jog_pkg::*;

    typedef struct packed {
        jog_state_e  state;
        par_s        par;
        par_rsp_s    rsp;
        motion_cmd_s cmd;
        logic [31:0] base;
        logic [1:0]  prev_dir;
        logic        fast_sel;
        logic        halted;
        logic        mode_q;
        logic        done;
    } jog_st_s;

    jog_st_s st_reg;
    jog_st_s st_next;

    logic [1:0]  req_dir;
    logic        dir_onehot;
    logic        held;
    logic        interrupt;
    logic        start;
    logic        timer_start;
    logic        timer_expired;
    logic [15:0] speed_sel;

    // one decode serves both the write and the read path
    function automatic logic [2:0] par_index(input logic [15:0] addr);
        unique case (addr)
            `JOG_OFS_SLOW_SPEED: par_index = 3'h1;
            `JOG_OFS_FAST_SPEED: par_index = 3'h2;
            `JOG_OFS_STEP_DIST:  par_index = 3'h3;
            `JOG_OFS_WAIT_TIME:  par_index = 3'h4;
            default:             par_index = 3'h0;
        endcase
    endfunction

    // request decoding
    assign req_dir    = jog_request_bits[`JOG_BIT_NEG:`JOG_BIT_POS];
    assign dir_onehot = req_dir[0] ^ req_dir[1];
    // with both bits set, the running direction's bit is still seen as held
    assign held       = st_reg.cmd.dir_neg ? req_dir[1] : req_dir[0];
    assign interrupt  = halt_req | fault | !mode_active;
    // only a fresh single-direction request starts a jog
    assign start      = (st_reg.state == ST_IDLE) && mode_active && !halt_req && !fault
                        && dir_onehot && (req_dir != st_reg.prev_dir);
    assign timer_start = start;
    // on the start cycle the live bit decides, so the step leaves at the right speed
    assign speed_sel  = (start ? jog_request_bits[`JOG_BIT_FAST] : st_reg.fast_sel)
                        ? st_reg.par.fast_jog_speed
                        : st_reg.par.slow_jog_speed;

    jog_wait_timer #(
        .CYCLES_PER_MS (CYCLES_PER_MS)
    ) u_wait_timer (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .clk_en  (clk_en),
        .start   (timer_start),
        .wait_ms (st_reg.par.continuous_wait_time),
        .expired (timer_expired)
    );

    // parameter port, mode capture and jog sequence
    always_comb begin
        st_next           = st_reg;
        st_next.rsp.valid = 1'b0;
        st_next.rsp.err   = 1'b0;
        st_next.done      = 1'b0;
        st_next.prev_dir  = req_dir;
        st_next.mode_q    = mode_active;

        // writes out of range are refused and keep the old value
        if (par_req.wr) begin
            st_next.rsp.valid = 1'b1;
            unique case (par_index(par_req.addr))
                3'h1: begin
                    if (par_req.wdata[31:16] == 16'h0000
                        && par_req.wdata[15:0] <= `JOG_SPEED_MAX) begin
                        st_next.par.slow_jog_speed = par_req.wdata[15:0];
                    end else begin
                        st_next.rsp.err = 1'b1;
                    end
                end
                3'h2: begin
                    if (par_req.wdata[31:16] == 16'h0000
                        && par_req.wdata[15:0] <= `JOG_SPEED_MAX) begin
                        st_next.par.fast_jog_speed = par_req.wdata[15:0];
                    end else begin
                        st_next.rsp.err = 1'b1;
                    end
                end
                3'h3: begin
                    if (par_req.wdata <= `JOG_STEP_MAX) begin
                        st_next.par.jog_step_distance = par_req.wdata;
                    end else begin
                        st_next.rsp.err = 1'b1;
                    end
                end
                3'h4: begin
                    if (par_req.wdata[31:16] == 16'h0000
                        && par_req.wdata[15:0] >= `JOG_WAIT_MIN
                        && par_req.wdata[15:0] <= `JOG_WAIT_MAX) begin
                        st_next.par.continuous_wait_time = par_req.wdata[15:0];
                    end else begin
                        st_next.rsp.err = 1'b1;
                    end
                end
                default: st_next.rsp.err = 1'b1;
            endcase
        end else if (par_req.rd) begin
            st_next.rsp.valid = 1'b1;
            unique case (par_index(par_req.addr))
                3'h1:    st_next.rsp.rdata = {16'h0000, st_reg.par.slow_jog_speed};
                3'h2:    st_next.rsp.rdata = {16'h0000, st_reg.par.fast_jog_speed};
                3'h3:    st_next.rsp.rdata = st_reg.par.jog_step_distance;
                3'h4:    st_next.rsp.rdata = {16'h0000, st_reg.par.continuous_wait_time};
                default: begin
                    st_next.rsp.rdata = 32'h00000000;
                    st_next.rsp.err   = 1'b1;
                end
            endcase
        end

        // start point is the position at the moment the mode comes up
        if (mode_active && !st_reg.mode_q) begin
            st_next.base   = actual_position;
        end

        // clamp every cycle so a lowered ceiling takes effect at once
        st_next.cmd.speed_ref = (speed_sel > ramp_speed_ceiling) ? ramp_speed_ceiling
                                                                 : speed_sel;

        unique case (st_reg.state)
            ST_IDLE: begin
                if (start) begin
                    st_next.cmd.dir_neg = req_dir[1];
                    st_next.fast_sel    = jog_request_bits[`JOG_BIT_FAST];
                    st_next.halted      = 1'b0;
                    if (st_reg.par.jog_step_distance == 32'h00000000) begin
                        st_next.state              = ST_CONT;
                        st_next.cmd.continuous_run = 1'b1;
                    end else begin
                        st_next.state           = ST_STEP;
                        st_next.cmd.step_active = 1'b1;
                        st_next.cmd.target_position = req_dir[1]
                            ? st_reg.base - st_reg.par.jog_step_distance
                            : st_reg.base + st_reg.par.jog_step_distance;
                    end
                end
            end
            ST_STEP: begin
                if (interrupt) begin
                    st_next.state  = ST_STOP;
                    st_next.halted = 1'b1;
                end else if (!held) begin
                    // the step already commanded runs out before the end
                    st_next.state = ST_STOP;
                end else if (timer_expired) begin
                    st_next.state              = ST_CONT;
                    st_next.cmd.step_active    = 1'b0;
                    st_next.cmd.continuous_run = 1'b1;
                end
            end
            ST_CONT: begin
                if (interrupt) begin
                    st_next.state  = ST_STOP;
                    st_next.halted = 1'b1;
                end else if (!held) begin
                    st_next.state = ST_STOP;
                end
                if (interrupt || !held) begin
                    st_next.cmd.continuous_run = 1'b0;
                end
            end
            ST_STOP: begin
                if (interrupt) begin
                    st_next.halted = 1'b1;
                end
                if (motor_standstill && (!held || st_reg.halted || interrupt)) begin
                    st_next.state           = ST_IDLE;
                    st_next.cmd.step_active = 1'b0;
                    st_next.done            = 1'b1;
                    // after any jog, step or free run, the next step begins where the motor stands
                    st_next.base            = actual_position;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg                          <= '0;
            st_reg.state                    <= ST_IDLE;
            st_reg.par.slow_jog_speed       <= `JOG_RST_SLOW_SPEED;
            st_reg.par.fast_jog_speed       <= `JOG_RST_FAST_SPEED;
            st_reg.par.jog_step_distance    <= `JOG_RST_STEP_DIST;
            st_reg.par.continuous_wait_time <= `JOG_RST_WAIT_TIME;
            st_reg.prev_dir                 <= 2'(`JOG_RST_REQUEST);
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign par_rsp    = st_reg.rsp;
    assign motion_cmd = st_reg.cmd;
    assign jog_busy   = (st_reg.state != ST_IDLE);
    assign jog_done   = st_reg.done;

    // checks on the sequence
    sequence s_start_step;
        start && (st_reg.par.jog_step_distance != 32'h00000000) && clk_en;
    endsequence

    sequence s_halt_stop;
        (st_reg.state == ST_STOP) && st_reg.halted;
    endsequence

    property p_both_no_start;
        @(posedge ref_clk) disable iff (!resetn)
        (st_reg.state == ST_IDLE) && (req_dir == 2'b11) |=> (st_reg.state == ST_IDLE);
    endproperty
    a_both_no_start: assert property (p_both_no_start) else $error("start on both directions");

    property p_both_running;
        @(posedge ref_clk) disable iff (!resetn)
        (st_reg.state == ST_CONT) && (req_dir == 2'b11) && !interrupt
            |=> (st_reg.state == ST_CONT) && motion_cmd.continuous_run;
    endproperty
    a_both_running: assert property (p_both_running) else $error("run changed by both bits");

    property p_step_first;
        @(posedge ref_clk) disable iff (!resetn)
        s_start_step |=> motion_cmd.step_active && !motion_cmd.continuous_run
            && (motion_cmd.target_position == ($past(req_dir[1])
                ? $past(st_reg.base) - $past(st_reg.par.jog_step_distance)
                : $past(st_reg.base) + $past(st_reg.par.jog_step_distance)));
    endproperty
    a_step_first: assert property (p_step_first) else $error("step not commanded first");

    property p_zero_step;
        @(posedge ref_clk) disable iff (!resetn)
        start && clk_en && (st_reg.par.jog_step_distance == 32'h00000000)
            |=> (st_reg.state == ST_CONT) && motion_cmd.continuous_run;
    endproperty
    a_zero_step: assert property (p_zero_step) else $error("zero step did not run");

    property p_go_cont;
        @(posedge ref_clk) disable iff (!resetn)
        (st_reg.state == ST_STEP) && clk_en && !interrupt && held && timer_expired
            |=> motion_cmd.continuous_run ##1 (motion_cmd.continuous_run || !$past(held)
                || $past(interrupt));
    endproperty
    a_go_cont: assert property (p_go_cont) else $error("no switch to continuous run");

    property p_speed_clamp;
        @(posedge ref_clk) disable iff (!resetn)
        clk_en |=> (motion_cmd.speed_ref <= $past(ramp_speed_ceiling));
    endproperty
    a_speed_clamp: assert property (p_speed_clamp) else $error("speed above ceiling");

    property p_fast_latch;
        @(posedge ref_clk) disable iff (!resetn)
        start && clk_en |=> (st_reg.fast_sel == $past(jog_request_bits[`JOG_BIT_FAST]));
    endproperty
    a_fast_latch: assert property (p_fast_latch) else $error("speed bit not latched");

    property p_finish;
        @(posedge ref_clk) disable iff (!resetn)
        (st_reg.state == ST_STOP) && clk_en && motor_standstill && !held
            |=> (st_reg.state == ST_IDLE) && jog_done;
    endproperty
    a_finish: assert property (p_finish) else $error("jog did not finish");

    property p_halt_end;
        @(posedge ref_clk) disable iff (!resetn)
        (st_reg.state != ST_IDLE) && clk_en && (halt_req || fault)
            |=> s_halt_stop or (st_reg.state == ST_IDLE);
    endproperty
    a_halt_end: assert property (p_halt_end) else $error("halt did not stop jog");

endmodule // jog_motion_sequencer

// >>> sim/jog_host_model.sv
module jog_host_model (
    // clock
    input  wire logic              ref_clk,
    // parameter port
    output jog_pkg::par_req_s      par_req,
    input  wire jog_pkg::par_rsp_s par_rsp,
    // jog control
    output logic [15:0]            jog_request_bits,
    output logic                   mode_active
);
    timeunit 1ns;
    timeprecision 1ps;
    import jog_pkg::*;

    logic [31:0] last_rdata;
    logic        last_err;

    // host idles with no strobe, no request and the mode off
    initial begin
        par_req          = '0;
        jog_request_bits = 16'h0000;
        mode_active      = 1'b0;
    end

    // one strobe cycle, then wait a bounded time for the answer marker
    task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] data);
        int i;
        @(posedge ref_clk);
        #1;
        par_req.addr  = addr;
        par_req.wdata = data;
        par_req.wr    = wr;
        par_req.rd    = ~wr;
        @(posedge ref_clk);
        #1;
        par_req.wr = 1'b0;
        par_req.rd = 1'b0;
        last_rdata = 'x;
        last_err   = 1'bx;
        for (i = 0; i < 4 && par_rsp.valid !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (par_rsp.valid === 1'b1) begin
            last_rdata = par_rsp.rdata;
            last_err   = par_rsp.err;
        end
    endtask

    // mode enabled once, on its own, after the drive is ready
    task automatic enable_mode();
        @(posedge ref_clk);
        #1 mode_active = 1'b1;
    endtask

    // bit0 positive, bit1 negative, bit2 fast; upper bits left clear
    task automatic set_request(input logic [2:0] bits);
        @(posedge ref_clk);
        #1 jog_request_bits = {13'h0000, bits};
    endtask
endmodule // jog_host_model

// >>> sim/jog_motion_sequencer_tb.sv
`include "jog_defs.svh"
module jog_motion_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import jog_pkg::*;

    localparam int CPM = 4;
    localparam logic [15:0] OFS [4] = '{`JOG_OFS_SLOW_SPEED, `JOG_OFS_FAST_SPEED,
                                        `JOG_OFS_STEP_DIST, `JOG_OFS_WAIT_TIME};

    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        clk_en = 1'b1;
    logic        halt_req = 1'b0;
    logic        fault = 1'b0;
    logic        motor_standstill = 1'b1;
    logic [31:0] actual_position = 32'h0000_1000;
    logic [15:0] ramp_speed_ceiling = 16'h3390;
    logic [15:0] jog_request_bits;
    logic        mode_active;
    par_req_s    par_req;
    par_rsp_s    par_rsp;
    motion_cmd_s motion_cmd;
    logic        jog_busy;
    logic        jog_done;
    int          fail_count = 0;
    int          checks = 0;
    int          seed = 89873;
    int          mdl [4] = '{60, 180, 20, 500};
    int          base;

    always #2 ref_clk = ~ref_clk;

    jog_motion_sequencer #(.CYCLES_PER_MS(CPM)) dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .par_req(par_req),
        .par_rsp(par_rsp), .jog_request_bits(jog_request_bits), .mode_active(mode_active),
        .halt_req(halt_req), .fault(fault), .actual_position(actual_position),
        .motor_standstill(motor_standstill), .ramp_speed_ceiling(ramp_speed_ceiling),
        .motion_cmd(motion_cmd), .jog_busy(jog_busy), .jog_done(jog_done));

    jog_host_model host_u (
        .ref_clk(ref_clk), .par_req(par_req), .par_rsp(par_rsp),
        .jog_request_bits(jog_request_bits), .mode_active(mode_active));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // model keeps a write only when it lies in the accepted range
    task automatic wr_par(input int idx, input logic [31:0] d);
        logic ok;
        ok = (idx < 2) ? (d <= 32'd13200) : (idx == 2) ? (d <= 32'h7FFF_FFFF)
                                                       : (d >= 32'd1 && d <= 32'd32767);
        host_u.access(1'b1, OFS[idx], d);
        chk("write_err", !ok, host_u.last_err);
        if (ok)
            mdl[idx] = d;
    endtask

    task automatic rd_all();
        for (int i = 0; i < 4; i++) begin
            host_u.access(1'b0, OFS[i], 32'h0000_0000);
            chk("read_data", mdl[i], host_u.last_rdata);
        end
    endtask

    function automatic int exp_speed(input logic fast);
        int v;
        v = fast ? mdl[1] : mdl[0];
        return (v > ramp_speed_ceiling) ? ramp_speed_ceiling : v;
    endfunction

    // request goes out with the motor leaving standstill; answer lands one cycle on
    task automatic start_jog(input logic [2:0] bits);
        int t;
        t = bits[1] ? base - mdl[2] : base + mdl[2];
        host_u.set_request(bits);
        motor_standstill = 1'b0;
        @(posedge ref_clk);
        #1;
        chk("busy", 1'b1, jog_busy);
        chk("dir_neg", bits[1], motion_cmd.dir_neg);
        chk("speed_ref", exp_speed(bits[2]), motion_cmd.speed_ref);
        if (mdl[2] == 0) begin
            chk("cont_run", 1'b1, motion_cmd.continuous_run);
        end else begin
            chk("step_active", 1'b1, motion_cmd.step_active);
            chk("target", t, motion_cmd.target_position);
        end
    endtask

    // keep shows what is still requested while the motor comes to rest
    task automatic end_jog(input logic [2:0] keep);
        int i;
        host_u.set_request(keep);
        actual_position = $random(seed);
        repeat (3) @(posedge ref_clk);
        #1 motor_standstill = 1'b1;
        for (i = 0; i < 8 && jog_done !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("done", 1'b1, jog_done);
        @(posedge ref_clk);
        #1;
        chk("busy_end", 1'b0, jog_busy);
        chk("step_end", 1'b0, motion_cmd.step_active);
        base = actual_position;
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        #1 resetn = 1'b1;
        rd_all();
        host_u.access(1'b0, 16'h290C, 32'h0000_0000);
        chk("unmapped_err", 1'b1, host_u.last_err);
        chk("unmapped_data", 32'h0, host_u.last_rdata);
        // range edges, refused ones must leave the old value
        wr_par(0, 32'd13201);
        wr_par(1, 32'd13200);
        wr_par(2, 32'h8000_0000);
        wr_par(2, 32'h7FFF_FFFF);
        wr_par(3, 32'd0);
        wr_par(3, 32'd32768);
        wr_par(3, 32'd32767);
        rd_all();
        wr_par(1, 32'd180);
        wr_par(2, 32'd1 + ($random(seed) & 32'h3FF));
        wr_par(3, 32'd3);
        host_u.enable_mode();
        base = actual_position;
        repeat (2) @(posedge ref_clk);
        // short tap: step only, released before the wait runs out
        start_jog(3'b001);
        repeat (CPM) @(posedge ref_clk);
        #1 chk("no_cont_early", 1'b0, motion_cmd.continuous_run);
        end_jog(3'b000);
        // held fast negative: continuous after 3 ms, both bits then ignored
        start_jog(3'b110);
        repeat (3 * CPM + 4) @(posedge ref_clk);
        #1 chk("cont_run", 1'b1, motion_cmd.continuous_run);
        chk("step_off", 1'b0, motion_cmd.step_active);
        host_u.set_request(3'b111);
        repeat (4) @(posedge ref_clk);
        #1 chk("both_running", 1'b1, motion_cmd.continuous_run);
        chk("dir_kept", 1'b1, motion_cmd.dir_neg);
        // enable low freezes the run although the request drops
        clk_en = 1'b0;
        host_u.set_request(3'b000);
        repeat (3) @(posedge ref_clk);
        #1 chk("frozen_run", 1'b1, motion_cmd.continuous_run);
        chk("frozen_busy", 1'b1, jog_busy);
        clk_en = 1'b1;
        end_jog(3'b000);
        // both bits from idle start nothing
        host_u.set_request(3'b011);
        repeat (4) @(posedge ref_clk);
        #1 chk("both_idle", 1'b0, jog_busy);
        host_u.set_request(3'b000);
        // zero step, with a random ceiling of 40 to 295 that clamps the fast speed of 180 only when below it
        wr_par(2, 32'd0);
        ramp_speed_ceiling = 16'd40 + ($random(seed) & 16'h00FF);
        start_jog(3'b101);
        end_jog(3'b000);
        ramp_speed_ceiling = 16'h3390;
        wr_par(2, 32'd7);
        // halt then fault while running; request still held at the end
        for (int k = 0; k < 2; k++) begin
            start_jog(3'b010);
            repeat (3 * CPM + 1) @(posedge ref_clk);
            #1 chk("cont_before_halt", 1'b1, motion_cmd.continuous_run);
            halt_req = (k == 0);
            fault = (k == 1);
            @(posedge ref_clk);
            #1 chk("stop_cont", 1'b0, motion_cmd.continuous_run);
            end_jog(3'b010);
            halt_req = 1'b0;
            fault = 1'b0;
            repeat (3) @(posedge ref_clk);
            #1 chk("no_restart", 1'b0, jog_busy);
            host_u.set_request(3'b000);
        end
        tally_and_finish();
    end

    // generous limit: the sequence needs well under ten thousand cycles
    initial begin
        #200000;
        fail_count++;
        $display("MISMATCH watchdog expected finish seen hang");
        tally_and_finish();
    end
endmodule // jog_motion_sequencer_tb
